//--- edpc_defines.svh
`ifndef EDPC_DEFINES_SVH
`define EDPC_DEFINES_SVH

// register indices; byte address is four times the index
`define EDPC_IDX_RESULT     8'h3A
`define EDPC_IDX_PATTERN    8'h3F
`define EDPC_IDX_EDCTRL     8'h41
`define EDPC_IDX_LEN_HIGH   8'h42
`define EDPC_IDX_LEN_LOW    8'h43
`define EDPC_IDX_IRQ_STATUS 8'h50
`define EDPC_IDX_IRQ_MASK   8'h51

// reset values
`define EDPC_RST_EDCTRL     8'hA0
`define EDPC_RST_LEN_HIGH   8'h00
`define EDPC_RST_LEN_LOW    8'h08
`define EDPC_RST_PATTERN    4'h5
`define EDPC_RST_IRQ        3'h0
`define EDPC_RST_RESULT     8'h00

// energy control field positions
`define EDPC_BIT_CALC_EN    7
`define EDPC_BIT_POST_SEL   6
`define EDPC_BIT_SRC_SEL    5
`define EDPC_BIT_DONE       4
`define EDPC_BIT_CAPTURE    3
`define EDPC_AVG_HI         2
`define EDPC_AVG_LO         0

// interrupt status and mask field positions
`define EDPC_IRQ_ENERGY     0
`define EDPC_IRQ_CHECK      1
`define EDPC_IRQ_LEAD_IN    2

// averaging code limits
`define EDPC_AVG_MAX_CODE   3'h5
`define EDPC_AVG_DEF_SHIFT  3'h4

// bus answers
`define EDPC_RESP_OKAY      2'h0
`define EDPC_RESP_SLVERR    2'h2

`endif

//--- edpc_pkg.sv
package edpc_pkg;

	// lead-in serializer states
	typedef enum logic {
		EDPC_TX_IDLE,
		EDPC_TX_SEND
	} edpc_tx_e;

	// sample and result width
	typedef logic [7:0] edpc_energy_t;

	// averaging code to shift count; unlisted codes fall back to a shift of 4 (16 samples)
	function automatic logic [2:0] edpc_avg_shift(input logic [2:0] code);
		if (code <= 3'h5) begin
			return code;
		end else begin
			return 3'h4;
		end
	endfunction

endpackage

//--- edpc_avg.sv
`timescale 1ns/10ps
`include "edpc_defines.svh"

// power-of-two block averager for energy samples
module edpc_avg (
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire logic                 ce,
	input  wire logic                 enable,
	input  wire edpc_pkg::edpc_energy_t sample,
	input  wire logic                 sample_valid,
	input  wire logic [2:0]           avg_code,
	output      edpc_pkg::edpc_energy_t result,
	output      logic                 result_valid,
	output      logic                 started
);

	logic [12:0] acc;   // running sum, room for 32 samples
	logic [5:0]  count; // samples taken in this window
	logic [2:0]  shift; // log2 of window length
	logic [12:0] sum;   // sum including current sample
	logic        last;  // current sample closes the window

	always_comb begin
		shift = edpc_pkg::edpc_avg_shift(avg_code);
		sum   = acc + {5'h00, sample};
		last  = (count == 6'((7'h01 << shift) - 7'h01));
	end

	// accumulate; disabling drops a partial window so a restart is clean
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			acc          <= 13'h0000;
			count        <= 6'h00;
			result       <= 8'h00;
			result_valid <= 1'b0;
			started      <= 1'b0;
		end else if (ce) begin
			result_valid <= 1'b0;
			started      <= 1'b0;
			if (!enable) begin
				acc   <= 13'h0000;
				count <= 6'h00;
			end else if (sample_valid) begin
				started <= (count == 6'h00);
				if (last) begin
					result       <= 8'(sum >> shift);
					result_valid <= 1'b1;
					acc          <= 13'h0000;
					count        <= 6'h00;
				end else begin
					acc   <= sum;
					count <= count + 6'h01;
				end
			end
		end
	end

endmodule

//--- edpc_top.sv
`timescale 1ns/10ps
`include "edpc_defines.svh"

// Functional notes
// (R1) compute energy only while calculation enable set
// (R2) select zero: idle sleeps, carrier keeps receiving
// (R3) select one: idle goes transmit, carrier sleeps
// (R4) post-check select acts only in quick mode
// (R5) quick check source: normal or double-width filter
// (R6) completion flag: zero busy, one done
// (R7) result continuous, or held from sync capture
// (R8) capture mode refreshes result on fifo read
// (R9) averaging code picks 1 to 32 samples
// (R10) host changes averaging only while stopped
// (R11) lead-in bits are twice sixteen-bit length
// (R12) host keeps length at least 0x0010
// (R13) pattern repeats msb first over lead-in
// (R14) flag clears at start, sets at result
module edpc_top (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        ce,
	input  wire logic [11:0] awaddr,
	input  wire logic        awvalid,
	output      logic        awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output      logic        wready,
	output      logic [1:0]  bresp,
	output      logic        bvalid,
	input  wire logic        bready,
	input  wire logic [11:0] araddr,
	input  wire logic        arvalid,
	output      logic        arready,
	output      logic [31:0] rdata,
	output      logic [1:0]  rresp,
	output      logic        rvalid,
	input  wire logic        rready,
	input  wire logic [7:0]  normal_energy,
	input  wire logic        normal_energy_valid,
	input  wire logic [7:0]  wide_energy,
	input  wire logic        wide_energy_valid,
	input  wire logic        quick_carrier_check_enable,
	input  wire logic        check_done,
	input  wire logic        carrier_found,
	input  wire logic        sync_detected,
	input  wire logic        rx_fifo_read,
	input  wire logic        tx_start,
	input  wire logic        tx_bit_tick,
	output      logic        go_sleep,
	output      logic        go_tx_on,
	output      logic        stay_rx,
	output      logic [7:0]  energy_result_value,
	output      logic        tx_lead_in_active,
	output      logic        tx_lead_in_bit,
	output      logic        tx_lead_in_done,
	output      logic        irq
);

	// register contents
	logic [7:0]  energy_detect_control;   // calc, mode, source, flag, avg
	logic [7:0]  tx_preamble_length_high; // lead-in length upper byte
	logic [7:0]  tx_preamble_length_low;  // lead-in length lower byte
	logic [3:0]  lead_in_pattern;         // repeated lead-in pattern
	logic [2:0]  irq_status;              // sticky events
	logic [2:0]  irq_mask;                // one enables an event
	logic [2:0]  next_irq_status;         // status after clears and events
	logic [7:0]  energy_live;             // newest average
	logic [7:0]  energy_captured;         // average at sync detect

	// bus staging
	logic [11:0] aw_addr_q;   // held write address
	logic [31:0] w_data_q;    // held write data
	logic [3:0]  w_strb_q;    // held byte enables
	logic        aw_held;     // write address taken
	logic        w_held;      // write data taken
	logic        do_write;    // both halves present, commit now
	logic [7:0]  wr_idx;      // decoded write index
	logic        wr_ok;       // aligned and in range
	logic        wr_lane;     // low byte lane enabled
	logic [7:0]  rd_idx;      // decoded read index
	logic [31:0] next_rdata;  // read mux
	logic [1:0]  next_rresp;  // read answer

	// averager hookup
	logic        use_wide;      // quick check on the wide filter
	logic [7:0]  avg_sample;    // selected source sample
	logic        avg_sample_ok; // selected source strobe
	logic [7:0]  avg_result;    // finished average
	logic        avg_valid;     // average finished this cycle
	logic        avg_started;   // first sample of a window taken

	// lead-in serializer
	edpc_pkg::edpc_tx_e tx_state;   // serializer state
	logic [16:0]        bits_left;  // lead-in bits still to send
	logic [1:0]         pat_idx;    // next pattern bit
	logic [16:0]        lead_bits;  // programmed length in bits

	// strips the word offset from a byte address; flags misalignment
	function automatic logic [8:0] decode_addr(input logic [11:0] a);
		return {(a[1:0] == 2'h0) && (a[11:10] == 2'h0), a[9:2]};
	endfunction

	// tells whether an index names a register of this block
	function automatic logic idx_mapped(input logic [7:0] i);
		if (i == `EDPC_IDX_RESULT) begin
			return 1'b1;
		end else if (i == `EDPC_IDX_PATTERN) begin
			return 1'b1;
		end else if (i >= `EDPC_IDX_EDCTRL && i <= `EDPC_IDX_LEN_LOW) begin
			return 1'b1;
		end else if (i == `EDPC_IDX_IRQ_STATUS) begin
			return 1'b1;
		end else if (i == `EDPC_IDX_IRQ_MASK) begin
			return 1'b1;
		end else begin
			return 1'b0;
		end
	endfunction

	always_comb begin
		do_write = aw_held && w_held && !bvalid;
		{wr_ok, wr_idx} = decode_addr(aw_addr_q);
		wr_ok   = wr_ok && idx_mapped(wr_idx);
		wr_lane = w_strb_q[0];
	end

	// write address and data are taken in either order, one write at a time
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready   <= 1'b1;
			wready    <= 1'b1;
			aw_held   <= 1'b0;
			w_held    <= 1'b0;
			aw_addr_q <= 12'h000;
			w_data_q  <= 32'h0000_0000;
			w_strb_q  <= 4'h0;
			bvalid    <= 1'b0;
			bresp     <= `EDPC_RESP_OKAY;
		end else if (ce) begin
			if (awvalid && awready) begin
				aw_addr_q <= awaddr;
				aw_held   <= 1'b1;
				awready   <= 1'b0;
			end
			if (wvalid && wready) begin
				w_data_q <= wdata;
				w_strb_q <= wstrb;
				w_held   <= 1'b1;
				wready   <= 1'b0;
			end
			if (do_write) begin
				bvalid  <= 1'b1;
				bresp   <= wr_ok ? `EDPC_RESP_OKAY : `EDPC_RESP_SLVERR;
				aw_held <= 1'b0;
				w_held  <= 1'b0;
			end else if (bvalid && bready) begin
				// reopen only after the answer, so writes never overlap
				bvalid  <= 1'b0;
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	// read mux; reserved bits and unmapped indices read zero
	always_comb begin
		logic ok;
		ok = 1'b0;
		{ok, rd_idx} = decode_addr(araddr);
		next_rdata = 32'h0000_0000;
		next_rresp = `EDPC_RESP_OKAY;
		if (!ok || !idx_mapped(rd_idx)) begin
			next_rresp = `EDPC_RESP_SLVERR;
		end else if (rd_idx == `EDPC_IDX_RESULT) begin
			next_rdata[7:0] = energy_result_value;
		end else if (rd_idx == `EDPC_IDX_PATTERN) begin
			next_rdata[3:0] = lead_in_pattern;
		end else if (rd_idx == `EDPC_IDX_EDCTRL) begin
			next_rdata[7:0] = energy_detect_control;
		end else if (rd_idx == `EDPC_IDX_LEN_HIGH) begin
			next_rdata[7:0] = tx_preamble_length_high;
		end else if (rd_idx == `EDPC_IDX_LEN_LOW) begin
			next_rdata[7:0] = tx_preamble_length_low;
		end else if (rd_idx == `EDPC_IDX_IRQ_STATUS) begin
			next_rdata[2:0] = irq_status;
		end else begin
			next_rdata[2:0] = irq_mask;
		end
	end

	// read channel; data is sampled the cycle the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= `EDPC_RESP_OKAY;
		end else if (ce) begin
			if (arvalid && arready) begin
				arready <= 1'b0;
				rvalid  <= 1'b1;
				rdata   <= next_rdata;
				rresp   <= next_rresp;
			end else if (rvalid && rready) begin
				rvalid  <= 1'b0;
				arready <= 1'b1;
			end
		end
	end

	// configuration writes; a control write also loads the completion flag, but a hardware event in the same cycle wins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			energy_detect_control   <= `EDPC_RST_EDCTRL;
			tx_preamble_length_high <= `EDPC_RST_LEN_HIGH;
			tx_preamble_length_low  <= `EDPC_RST_LEN_LOW;
			lead_in_pattern         <= `EDPC_RST_PATTERN;
			irq_mask                <= `EDPC_RST_IRQ;
		end else if (ce) begin
			if (do_write && wr_ok && wr_lane) begin
				if (wr_idx == `EDPC_IDX_EDCTRL) begin
					energy_detect_control <= w_data_q[7:0];
				end else if (wr_idx == `EDPC_IDX_LEN_HIGH) begin
					tx_preamble_length_high <= w_data_q[7:0];
				end else if (wr_idx == `EDPC_IDX_LEN_LOW) begin
					tx_preamble_length_low <= w_data_q[7:0];
				end else if (wr_idx == `EDPC_IDX_PATTERN) begin
					lead_in_pattern <= w_data_q[3:0];
				end else if (wr_idx == `EDPC_IDX_IRQ_MASK) begin
					irq_mask <= w_data_q[2:0];
				end
			end
			// a hardware set or clear beats a software write of the flag
			if (avg_valid) begin
				energy_detect_control[`EDPC_BIT_DONE] <= 1'b1; // R6 R14
			end else if (avg_started) begin
				energy_detect_control[`EDPC_BIT_DONE] <= 1'b0; // R6 R14
			end
		end
	end

	// source choice: the wide filter only matters during a quick check
	always_comb begin
		use_wide = quick_carrier_check_enable &&
			energy_detect_control[`EDPC_BIT_SRC_SEL]; // R5
		avg_sample    = use_wide ? wide_energy : normal_energy;
		avg_sample_ok = use_wide ? wide_energy_valid : normal_energy_valid;
	end

	edpc_avg u_avg (
		.aclk         (aclk),
		.aresetn      (aresetn),
		.ce           (ce),
		.enable       (energy_detect_control[`EDPC_BIT_CALC_EN]), // R1
		.sample       (avg_sample),
		.sample_valid (avg_sample_ok),
		.avg_code     (energy_detect_control[`EDPC_AVG_HI:`EDPC_AVG_LO]), // R9
		.result       (avg_result),
		.result_valid (avg_valid),
		.started      (avg_started)
	);

	// shown result: live average, or the sync capture released by fifo read
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			energy_live         <= `EDPC_RST_RESULT;
			energy_captured     <= `EDPC_RST_RESULT;
			energy_result_value <= `EDPC_RST_RESULT;
		end else if (ce) begin
			if (avg_valid) begin
				energy_live <= avg_result;
			end
			if (sync_detected) begin
				energy_captured <= energy_live; // R7
			end
			if (!energy_detect_control[`EDPC_BIT_CAPTURE]) begin
				if (avg_valid) begin
					energy_result_value <= avg_result; // R7
				end
			end else if (rx_fifo_read) begin
				energy_result_value <= energy_captured; // R8
			end
		end
	end

	// radio state after a quick carrier check, one-cycle requests
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			go_sleep <= 1'b0;
			go_tx_on <= 1'b0;
			stay_rx  <= 1'b0;
		end else if (ce) begin
			go_sleep <= 1'b0;
			go_tx_on <= 1'b0;
			stay_rx  <= 1'b0;
			if (check_done && quick_carrier_check_enable) begin // R4
				if (!energy_detect_control[`EDPC_BIT_POST_SEL]) begin
					go_sleep <= !carrier_found; // R2
					stay_rx  <= carrier_found;  // R2
				end else begin
					go_tx_on <= !carrier_found; // R3
					go_sleep <= carrier_found;  // R3
				end
			end
		end
	end

	// the length register counts bit pairs
	assign lead_bits = {tx_preamble_length_high, tx_preamble_length_low,
		1'b0}; // R11

	// lead-in serializer; a zero length ends at once with no bits
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_state          <= edpc_pkg::EDPC_TX_IDLE;
			bits_left         <= 17'h00000;
			pat_idx           <= 2'h3;
			tx_lead_in_active <= 1'b0;
			tx_lead_in_bit    <= 1'b0;
			tx_lead_in_done   <= 1'b0;
		end else if (ce) begin
			tx_lead_in_done <= 1'b0;
			case (tx_state)
				edpc_pkg::EDPC_TX_IDLE: begin
					if (tx_start && lead_bits == 17'h00000) begin
						tx_lead_in_done <= 1'b1;
					end else if (tx_start) begin
						tx_state          <= edpc_pkg::EDPC_TX_SEND;
						bits_left         <= lead_bits; // R11
						tx_lead_in_active <= 1'b1;
						tx_lead_in_bit    <= lead_in_pattern[3]; // R13
						pat_idx           <= 2'h2;
					end
				end
				edpc_pkg::EDPC_TX_SEND: begin
					if (tx_bit_tick) begin
						bits_left <= bits_left - 17'h00001;
						if (bits_left == 17'h00001) begin
							tx_state          <= edpc_pkg::EDPC_TX_IDLE;
							tx_lead_in_active <= 1'b0;
							tx_lead_in_bit    <= 1'b0;
							tx_lead_in_done   <= 1'b1;
						end else begin
							tx_lead_in_bit <= lead_in_pattern[pat_idx]; // R13
							pat_idx        <= pat_idx - 2'h1;
						end
					end
				end
				default: begin
					tx_state <= edpc_pkg::EDPC_TX_IDLE;
				end
			endcase
		end
	end

	// sticky events, write one to clear; a same-cycle event wins
	always_comb begin
		next_irq_status = irq_status;
		if (do_write && wr_ok && wr_lane &&
			wr_idx == `EDPC_IDX_IRQ_STATUS) begin
			next_irq_status = next_irq_status & ~w_data_q[2:0];
		end
		next_irq_status[`EDPC_IRQ_ENERGY] =
			next_irq_status[`EDPC_IRQ_ENERGY] | avg_valid;
		next_irq_status[`EDPC_IRQ_CHECK] =
			next_irq_status[`EDPC_IRQ_CHECK] |
			(check_done && quick_carrier_check_enable);
		next_irq_status[`EDPC_IRQ_LEAD_IN] =
			next_irq_status[`EDPC_IRQ_LEAD_IN] | tx_lead_in_done;
	end

	// irq follows the new status so it never lags a clear by two cycles
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_status <= `EDPC_RST_IRQ;
			irq        <= 1'b0;
		end else if (ce) begin
			irq_status <= next_irq_status;
			irq        <= |(next_irq_status & irq_mask);
		end
	end

	// checks: bits sent per lead-in, counted beside the serializer
	logic [16:0] chk_sent;
	logic [16:0] chk_want;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			chk_sent <= 17'h00000;
			chk_want <= 17'h00000;
		end else if (ce) begin
			if (tx_state == edpc_pkg::EDPC_TX_IDLE && tx_start) begin
				chk_sent <= 17'h00000;
				chk_want <= lead_bits;
			end else if (tx_lead_in_active && tx_bit_tick) begin
				chk_sent <= chk_sent + 17'h00001;
			end
		end
	end

	sequence s_check_idle;
		ce && check_done && quick_carrier_check_enable && !carrier_found;
	endsequence
	sequence s_check_busy;
		ce && check_done && quick_carrier_check_enable && carrier_found;
	endsequence

	chk_calc_gated: assert property (@(posedge aclk) disable iff (!aresetn) // R1
		avg_valid |-> $past(energy_detect_control[`EDPC_BIT_CALC_EN]))
		else $error("average produced while calculation disabled");
	chk_sel0_idle: assert property (@(posedge aclk) disable iff (!aresetn) // R2
		s_check_idle and !energy_detect_control[`EDPC_BIT_POST_SEL]
		|=> go_sleep && !go_tx_on && !stay_rx)
		else $error("select zero idle did not sleep");
	chk_sel0_busy: assert property (@(posedge aclk) disable iff (!aresetn) // R2
		s_check_busy and !energy_detect_control[`EDPC_BIT_POST_SEL]
		|=> stay_rx && !go_sleep)
		else $error("select zero carrier did not keep receiving");
	chk_sel1_paths: assert property (@(posedge aclk) disable iff (!aresetn) // R3
		(s_check_idle and energy_detect_control[`EDPC_BIT_POST_SEL]
		|=> go_tx_on && !go_sleep) and
		(s_check_busy and energy_detect_control[`EDPC_BIT_POST_SEL]
		|=> go_sleep && !go_tx_on))
		else $error("select one outcome wrong");
	chk_quick_only: assert property (@(posedge aclk) disable iff (!aresetn) // R4
		ce && !quick_carrier_check_enable |=> !(go_sleep || go_tx_on || stay_rx))
		else $error("state request outside quick mode");
	chk_wide_source: assert property (@(posedge aclk) disable iff (!aresetn) // R5
		ce && use_wide && normal_energy_valid && !wide_energy_valid
		|=> !avg_started)
		else $error("normal filter used during wide quick check");
	chk_done_flag: assert property (@(posedge aclk) disable iff (!aresetn) // R14
		(ce && avg_valid |=> energy_detect_control[`EDPC_BIT_DONE]) and
		(ce && avg_started && !avg_valid
		|=> !energy_detect_control[`EDPC_BIT_DONE]))
		else $error("completion flag out of step");
	chk_result_hold: assert property (@(posedge aclk) disable iff (!aresetn) // R8
		ce && energy_detect_control[`EDPC_BIT_CAPTURE] && !rx_fifo_read
		|=> $stable(energy_result_value))
		else $error("held result changed without fifo read");
	chk_lead_in_len: assert property (@(posedge aclk) disable iff (!aresetn) // R11
		$fell(tx_lead_in_active) |-> chk_sent == chk_want)
		else $error("lead-in bit count wrong");
	chk_lead_in_msb: assert property (@(posedge aclk) disable iff (!aresetn) // R13
		$rose(tx_lead_in_active) |-> tx_lead_in_bit == lead_in_pattern[3])
		else $error("lead-in did not start at pattern msb");

endmodule

//--- edpc_host.sv
`timescale 1ns/10ps

// host-side register bus master: one write and one read at a time
module edpc_host (
	input  wire logic        aclk,
	output      logic [11:0] awaddr,
	output      logic        awvalid,
	input  wire logic        awready,
	output      logic [31:0] wdata,
	output      logic [3:0]  wstrb,
	output      logic        wvalid,
	input  wire logic        wready,
	input  wire logic        bvalid,
	output      logic        bready,
	output      logic [11:0] araddr,
	output      logic        arvalid,
	input  wire logic        arready,
	input  wire logic        rvalid,
	output      logic        rready
);
	// idle bus from time zero
	initial begin
		awaddr = 12'h000;
		awvalid = 1'b0;
		wdata = 32'h0;
		wstrb = 4'h0;
		wvalid = 1'b0;
		bready = 1'b0;
		araddr = 12'h000;
		arvalid = 1'b0;
		rready = 1'b0;
	end

	// address and data go out together; each drops once it is taken
	task automatic write(input logic [7:0] idx, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge aclk);
		awaddr <= {2'h0, idx, 2'h0};
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= 4'hF;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid && n < 200);
		bready <= 1'b0;
		// a slave that never answers ends the run
		if (n >= 200) begin
			tb.n_errors++;
			tb.wrap_up();
		end
	endtask

	// rready stays up until the answer is seen
	task automatic read(input logic [7:0] idx);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= {2'h0, idx, 2'h0};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (arready) arvalid <= 1'b0;
		end while (!rvalid && n < 200);
		rready <= 1'b0;
		if (n >= 200) begin
			tb.n_errors++;
			tb.wrap_up();
		end
	endtask
endmodule

//--- tb.sv
`timescale 1ns/10ps
`include "edpc_defines.svh"

// self-checking bench for the energy detect and lead-in block
module tb;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [7:0]  nrg = 8'h00, wnrg = 8'h00, res, old, v;
	logic        nrg_v = 1'b0, wnrg_v = 1'b0, quick = 1'b0, chk_p = 1'b0;
	logic        car = 1'b0, sync_p = 1'b0, fifo_p = 1'b0;
	logic        txs = 1'b0, tick = 1'b0;
	logic        go_sleep, go_tx_on, stay_rx, act, lbit, ldone, irq;
	logic [2:0]  seen, exp3;
	logic [3:0]  pat;
	logic [33:0] exp_q[$]; // expected bus answers, oldest first
	int          n_errors = 0, comparisons = 0, sum, sh;

	always #10 aclk = ~aclk; // 20 ns period

	edpc_top u_dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.normal_energy(nrg), .normal_energy_valid(nrg_v),
		.wide_energy(wnrg), .wide_energy_valid(wnrg_v),
		.quick_carrier_check_enable(quick), .check_done(chk_p),
		.carrier_found(car), .sync_detected(sync_p),
		.rx_fifo_read(fifo_p), .tx_start(txs), .tx_bit_tick(tick),
		.go_sleep(go_sleep), .go_tx_on(go_tx_on), .stay_rx(stay_rx),
		.energy_result_value(res), .tx_lead_in_active(act),
		.tx_lead_in_bit(lbit), .tx_lead_in_done(ldone), .irq(irq));

	edpc_host u_host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rvalid(rvalid), .rready(rready));

	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// the expectation is queued before the request goes out
	task automatic wr(input logic [7:0] i, input logic [7:0] d,
		input logic [1:0] r);
		exp_q.push_back({r, 32'h0});
		u_host.write(i, {24'h0, d});
	endtask

	task automatic rd(input logic [7:0] i, input logic [33:0] e);
		exp_q.push_back(e);
		u_host.read(i);
	endtask

	// one sample on both filters; the source select picks one
	task automatic smp(input logic [7:0] a, input logic [7:0] b);
		@(posedge aclk);
		nrg <= a;
		wnrg <= b;
		nrg_v <= 1'b1;
		wnrg_v <= 1'b1;
		@(posedge aclk);
		nrg_v <= 1'b0;
		wnrg_v <= 1'b0;
		repeat (4) @(posedge aclk);
	endtask

	task automatic wrap_up();
		$display("comparisons %0d n_errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// answer watcher: pairs each response with the oldest note
	always @(posedge aclk) begin
		if ((rvalid && rready) || (bvalid && bready)) begin
			if (exp_q.size() == 0) chk(34'h1, 34'h0);
			else chk(rvalid ? {rresp, rdata} : {bresp, 32'h0}, exp_q.pop_front());
		end
	end

	// hang guard
	initial begin
		repeat (100000) @(posedge aclk);
		n_errors++;
		wrap_up();
	end

	initial begin
		sum = $urandom(82020);
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`EDPC_IDX_EDCTRL, 34'hA0);
		rd(`EDPC_IDX_LEN_HIGH, 34'h00);
		rd(`EDPC_IDX_LEN_LOW, 34'h08);
		rd(`EDPC_IDX_IRQ_MASK, 34'h0);
		rd(8'h00, {2'h2, 32'h0});
		wr(8'h00, 8'hFF, 2'h2);
		// every select and carrier case, with and without quick mode
		for (int k = 0; k < 8; k++) begin
			wr(`EDPC_IDX_EDCTRL, {1'b0, k[1], 6'h0}, 2'h0);
			@(posedge aclk);
			quick <= k[2];
			car <= k[0];
			chk_p <= 1'b1;
			@(posedge aclk);
			chk_p <= 1'b0;
			#1 seen = {go_sleep, go_tx_on, stay_rx};
			repeat (3) begin
				@(posedge aclk);
				#1 seen |= {go_sleep, go_tx_on, stay_rx};
			end
			exp3 = k[1] ? (k[0] ? 3'h4 : 3'h2) : (k[0] ? 3'h1 : 3'h4);
			chk(seen, k[2] ? exp3 : 3'h0);
		end
		@(posedge aclk) quick <= 1'b0;
		// each averaging code, calculation stopped while it changes
		for (int c = 0; c < 8; c++) begin
			sh = (c <= 5) ? c : 4;
			wr(`EDPC_IDX_EDCTRL, c[7:0], 2'h0);
			wr(`EDPC_IDX_EDCTRL, 8'h80 | c[7:0], 2'h0);
			sum = 0;
			for (int i = 0; i < (1 << sh); i++) begin
				v = 8'($urandom);
				sum += v;
				if (i > 0 && i == (1 << sh) - 1)
					rd(`EDPC_IDX_EDCTRL, 34'h80 | c);
				smp(v, ~v);
			end
			chk(res, 34'(sum >> sh));
			rd(`EDPC_IDX_EDCTRL, 34'h90 | c);
			wr(`EDPC_IDX_EDCTRL, c[7:0], 2'h0);
		end
		old = res;
		wr(`EDPC_IDX_EDCTRL, 8'h00, 2'h0);
		smp(~old, old);
		chk(res, old);
		@(posedge aclk) quick <= 1'b1;
		wr(`EDPC_IDX_EDCTRL, 8'hA0, 2'h0);
		smp(8'h11, 8'hEE);
		@(posedge aclk) nrg_v <= 1'b1;
		@(posedge aclk) nrg_v <= 1'b0;
		repeat (3) @(posedge aclk);
		chk(res, 34'hEE);
		wr(`EDPC_IDX_EDCTRL, 8'h80, 2'h0);
		smp(8'h22, 8'hDD);
		chk(res, 34'h22);
		@(posedge aclk) quick <= 1'b0;
		// held result: captured at sync, shown after a fifo read
		wr(`EDPC_IDX_EDCTRL, 8'h88, 2'h0);
		smp(8'h5A, 8'h00);
		chk(res, 34'h22);
		@(posedge aclk) sync_p <= 1'b1;
		@(posedge aclk) sync_p <= 1'b0;
		smp(8'h33, 8'h00);
		chk(res, 34'h22);
		@(posedge aclk) fifo_p <= 1'b1;
		@(posedge aclk) fifo_p <= 1'b0;
		repeat (3) @(posedge aclk);
		chk(res, 34'h5A);
		rd(`EDPC_IDX_RESULT, 34'h5A);
		// lead-in: 0x0011 gives 34 bits, kept at or above 0x0010
		pat = 4'($urandom);
		v = 8'($urandom);
		wr(`EDPC_IDX_LEN_HIGH, v, 2'h0);
		rd(`EDPC_IDX_LEN_HIGH, {26'h0, v});
		wr(`EDPC_IDX_LEN_HIGH, 8'h00, 2'h0);
		wr(`EDPC_IDX_LEN_LOW, 8'h11, 2'h0);
		wr(`EDPC_IDX_PATTERN, {4'h0, pat}, 2'h0);
		@(posedge aclk) txs <= 1'b1;
		@(posedge aclk) txs <= 1'b0;
		#1;
		for (int i = 0; i < 34; i++) begin
			chk({act, lbit}, {1'b1, pat[3 - (i % 4)]});
			@(posedge aclk) tick <= 1'b1;
			@(posedge aclk) tick <= 1'b0;
			#1;
		end
		seen = {2'h0, ldone};
		@(posedge aclk);
		#1 seen |= {2'h0, ldone};
		chk({act, seen}, 4'h1);
		// interrupts: all three events pending, lead-in event unmasked, then cleared
		rd(`EDPC_IDX_IRQ_STATUS, 34'h7);
		chk(irq, 1'b0);
		wr(`EDPC_IDX_IRQ_MASK, 8'h04, 2'h0);
		repeat (3) @(posedge aclk);
		chk(irq, 1'b1);
		wr(`EDPC_IDX_IRQ_STATUS, 8'h04, 2'h0);
		repeat (3) @(posedge aclk);
		chk(irq, 1'b0);
		rd(`EDPC_IDX_IRQ_STATUS, 34'h3);
		repeat (5) @(posedge aclk);
		chk(exp_q.size(), 34'h0);
		wrap_up();
	end
endmodule
